// File: inc/mac_flow_pkg.sv
package mac_flow_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFF_HARDWARE_CONFIG_REG = 8'h00;
  localparam logic [7:0] OFF_FLOW = 8'h04;
  localparam logic [7:0] OFF_WAKE_A = 8'h08;
  localparam logic [7:0] OFF_WAKE_B = 8'h0c;
  localparam logic [7:0] OFF_PMT = 8'h10;
  localparam logic [7:0] OFF_WAKE_CAUSE = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CFG_HALF = 0;
  localparam int CFG_SPEED = 1;
  localparam int CFG_NORETRY = 3;
  localparam int CFG_FCS = 4;
  localparam int CFG_PAD = 5;
  localparam int CFG_STRIP = 6;
  localparam int CFG_BACKOFF_LIMIT_SEL = 8;
  localparam int FLOW_RXEN = 0;
  localparam int FLOW_TXEN = 1;
  localparam int FLOW_FWD = 2;
  localparam int FLOW_FORCE = 3;
  localparam int FLOW_TIME = 16;
  localparam int WAKE_STS = 4;
  localparam int PMT_WOL = 0;
  localparam int PMT_CLR_STS = 1;
  localparam int PMT_CLR_EN = 2;
  localparam int PMT_SUSP = 4;

  // ****************************************
  // Reset values and protocol constants
  // ****************************************
  localparam logic [1:0] SPEED_GIG = 2'h2;
  localparam logic [1:0] RST_SPEED = 2'h0;
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  localparam logic [9:0] SLOT_BITS = 10'h200;
  localparam logic [9:0] JAM_BITS = 10'h020;
  localparam logic [4:0] MAX_ATTEMPTS = 5'h10;
  localparam logic [15:0] CTL_ETHERTYPE = 16'h8808;
  localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    TX_IDLE = 5'h01,
    TX_SEND = 5'h02,
    TX_JAM = 5'h04,
    TX_BACKOFF = 5'h08,
    TX_PAUSE = 5'h10
  } tx_state_t;

endpackage

// File: verilog/mac_flow_wake.sv
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module mac_flow_wake (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // PHY side pins (asynchronous)
  input wire logic link_clk,
  input wire logic phy_collision,
  // Transmit datapath and FIFO controller
  input wire logic tx_frame_pending,
  input wire logic tx_frame_end,
  input wire logic pause_frame_sent,
  input wire logic flow_on,
  input wire logic flow_off,
  output logic tx_data_en,
  output logic tx_jam,
  output logic frame_replay_req,
  output logic frame_done_ind,
  output logic pause_frame_req,
  output logic [15:0] pause_frame_time,
  output logic tx_fcs_on,
  output logic tx_pad_on,
  output logic rx_pad_strip,
  output logic half_duplex_active,
  output logic tx_paused,
  // Receive control frame decode
  input wire logic rx_ctl_frame,
  input wire logic rx_da_reserved,
  input wire logic rx_da_unicast,
  input wire logic [15:0] rx_ctl_opcode,
  input wire logic [15:0] rx_pause_quanta,
  output logic rx_forward_ctl,
  // Wake events and power state
  input wire logic [5:0] wake_match,
  input wire logic suspend_enter,
  input wire logic suspend_rx_store,
  input wire logic resume_sig,
  output logic wake_req,
  output logic store_wake_frame,
  output logic normal_state
);

  typedef struct packed {
    logic [2:0] lclk_sync;
    logic [2:0] col_sync;
    logic lclk_level;
    logic col_level;
    mac_flow_pkg::tx_state_t tx_state;
    logic [9:0] bit_cnt;
    logic [4:0] attempts;
    logic [9:0] backoff_left;
    logic [15:0] lfsr;
    logic late;
    logic tx_data_en;
    logic tx_jam;
    logic frame_replay_req;
    logic frame_done_ind;
    logic [8:0] pause_bits;
    logic [15:0] pause_timer;
    logic pause_hold;
    logic [15:0] pause_hold_val;
    logic pause_req_pend;
    logic [15:0] pause_req_val;
    logic pause_frame_req;
    logic [15:0] pause_frame_time;
    logic flow_armed;
    logic rx_forward_ctl;
    logic half_duplex;
    logic [1:0] speed;
    logic retry_disable;
    logic fcs_en;
    logic pad_en;
    logic pad_strip;
    logic [1:0] backoff_limit_sel;
    logic rx_pause_enable;
    logic tx_pause_enable;
    logic forward_pause_enable;
    logic [15:0] pause_time_value;
    logic [5:0] wake_en;
    logic [5:0] wake_sts;
    logic [5:0] wake_cause;
    logic lan_wake_enable;
    logic resume_clears_status;
    logic resume_clears_enables;
    logic suspended;
    logic wake_req;
    logic store_wake_frame;
    logic normal;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t st;
  state_t next_st;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [9:0] backoff_mask(input logic [4:0] tries, input logic [1:0] sel);
    logic [4:0] lim;
    logic [4:0] k;
    case (sel)
      2'h0: lim = 5'h0a;
      2'h1: lim = 5'h08;
      2'h2: lim = 5'h04;
      default: lim = 5'h01;
    endcase
    k = (tries < lim) ? tries : lim;
    return 10'((11'h001 << k) - 11'h001);
  endfunction

  function automatic logic [31:0] read_reg(input state_t s, input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      mac_flow_pkg::OFF_HARDWARE_CONFIG_REG: begin
        r[mac_flow_pkg::CFG_HALF] = s.half_duplex;
        r[mac_flow_pkg::CFG_SPEED +: 2] = s.speed;
        r[mac_flow_pkg::CFG_NORETRY] = s.retry_disable;
        r[mac_flow_pkg::CFG_FCS] = s.fcs_en;
        r[mac_flow_pkg::CFG_PAD] = s.pad_en;
        r[mac_flow_pkg::CFG_STRIP] = s.pad_strip;
        r[mac_flow_pkg::CFG_BACKOFF_LIMIT_SEL +: 2] = s.backoff_limit_sel;
      end
      mac_flow_pkg::OFF_FLOW: begin
        r[mac_flow_pkg::FLOW_RXEN] = s.rx_pause_enable;
        r[mac_flow_pkg::FLOW_TXEN] = s.tx_pause_enable;
        r[mac_flow_pkg::FLOW_FWD] = s.forward_pause_enable;
        r[mac_flow_pkg::FLOW_FORCE] = s.pause_req_pend;
        r[mac_flow_pkg::FLOW_TIME +: 16] = s.pause_time_value;
      end
      mac_flow_pkg::OFF_WAKE_A: r[7:0] = {s.wake_sts[3:0], s.wake_en[3:0]};
      mac_flow_pkg::OFF_WAKE_B: r[7:0] = {2'h0, s.wake_sts[5:4], 2'h0, s.wake_en[5:4]};
      mac_flow_pkg::OFF_PMT: begin
        r[mac_flow_pkg::PMT_WOL] = s.lan_wake_enable;
        r[mac_flow_pkg::PMT_CLR_STS] = s.resume_clears_status;
        r[mac_flow_pkg::PMT_CLR_EN] = s.resume_clears_enables;
        r[mac_flow_pkg::PMT_SUSP] = s.suspended;
      end
      mac_flow_pkg::OFF_WAKE_CAUSE: r[5:0] = s.wake_cause;
      mac_flow_pkg::OFF_STATUS: r = {s.pause_timer, 3'h0, s.attempts, 3'h0, s.tx_state};
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= mac_flow_pkg::OFF_STATUS);
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic bit_tick;
    logic half_eff;
    logic col;
    logic pause_ok;
    logic [5:0] hits;
    logic [31:0] w;
    bit_tick = 1'b0;
    half_eff = 1'b0;
    col = 1'b0;
    pause_ok = 1'b0;
    hits = 6'h00;
    w = 32'h0000_0000;
    next_st = st;
    next_st.frame_replay_req = 1'b0;
    next_st.frame_done_ind = 1'b0;
    next_st.rx_forward_ctl = 1'b0;
    next_st.store_wake_frame = 1'b0;

    // Pins take three stages; a change counts once stages two and three agree
    next_st.lclk_sync = {st.lclk_sync[1:0], link_clk};
    next_st.col_sync = {st.col_sync[1:0], phy_collision};
    if (st.lclk_sync[2] == st.lclk_sync[1]) begin
      next_st.lclk_level = st.lclk_sync[2];
    end
    if (st.col_sync[2] == st.col_sync[1]) begin
      next_st.col_level = st.col_sync[2];
    end
    bit_tick = next_st.lclk_level & ~st.lclk_level;
    half_eff = st.half_duplex && (st.speed != mac_flow_pkg::SPEED_GIG);
    col = st.col_level & half_eff;
    next_st.lfsr = {st.lfsr[14:0], st.lfsr[15] ^ st.lfsr[13] ^ st.lfsr[12] ^ st.lfsr[10]};

    // Pause timer, one decrement per slot of link bit times
    if (bit_tick && (st.pause_timer != 16'h0000)) begin
      next_st.pause_bits = 9'(st.pause_bits + 9'h001);
      if (st.pause_bits == 9'(mac_flow_pkg::SLOT_BITS - 10'h001)) begin
        next_st.pause_timer = 16'(st.pause_timer - 16'h0001);
      end
    end

    // Received control frames are consumed here unless forward_pause_enable is set
    if (rx_ctl_frame) begin
      next_st.rx_forward_ctl = st.forward_pause_enable;
      pause_ok = (rx_da_reserved | rx_da_unicast) && (rx_ctl_opcode == mac_flow_pkg::PAUSE_OPCODE);
      if (pause_ok && st.rx_pause_enable) begin
        if (st.tx_state == mac_flow_pkg::TX_SEND) begin
          next_st.pause_hold = 1'b1;
          next_st.pause_hold_val = rx_pause_quanta;
        end else begin
          next_st.pause_timer = rx_pause_quanta;
          next_st.pause_bits = 9'h000;
        end
      end
    end

    // Transmit sequencing
    case (st.tx_state)
      mac_flow_pkg::TX_IDLE: begin
        if (st.pause_req_pend) begin
          // Control frames bypass the pause inhibit; FCS and pad follow fcs_en and pad_en
          next_st.pause_req_pend = 1'b0;
          next_st.pause_frame_req = 1'b1;
          next_st.pause_frame_time = st.pause_req_val;
          next_st.tx_state = mac_flow_pkg::TX_PAUSE;
        end else if (tx_frame_pending && (st.pause_timer == 16'h0000)) begin
          next_st.tx_state = mac_flow_pkg::TX_SEND;
          next_st.tx_data_en = 1'b1;
          next_st.bit_cnt = 10'h000;
          next_st.late = 1'b0;
          next_st.attempts = 5'h00;
        end
      end
      mac_flow_pkg::TX_SEND: begin
        if (bit_tick && !st.late) begin
          next_st.bit_cnt = 10'(st.bit_cnt + 10'h001);
          next_st.late = (st.bit_cnt == 10'(mac_flow_pkg::SLOT_BITS - 10'h001));
        end
        if (col) begin
          next_st.tx_data_en = 1'b0;
          next_st.tx_jam = 1'b1;
          next_st.bit_cnt = 10'h000;
          next_st.tx_state = mac_flow_pkg::TX_JAM;
        end else if (tx_frame_end) begin
          next_st.tx_data_en = 1'b0;
          next_st.frame_done_ind = 1'b1;
          next_st.tx_state = mac_flow_pkg::TX_IDLE;
        end
      end
      mac_flow_pkg::TX_JAM: begin
        if (bit_tick) begin
          next_st.bit_cnt = 10'(st.bit_cnt + 10'h001);
          if (st.bit_cnt == 10'(mac_flow_pkg::JAM_BITS - 10'h001)) begin
            next_st.tx_jam = 1'b0;
            next_st.attempts = 5'(st.attempts + 5'h01);
            next_st.bit_cnt = 10'h000;
            if (st.retry_disable || st.late || (5'(st.attempts + 5'h01) >= mac_flow_pkg::MAX_ATTEMPTS)) begin
              next_st.frame_done_ind = 1'b1;
              next_st.tx_state = mac_flow_pkg::TX_IDLE;
            end else begin
              next_st.frame_replay_req = 1'b1;
              next_st.backoff_left = st.lfsr[9:0] &
                backoff_mask(5'(st.attempts + 5'h01), st.backoff_limit_sel);
              next_st.tx_state = mac_flow_pkg::TX_BACKOFF;
            end
          end
        end
      end
      mac_flow_pkg::TX_BACKOFF: begin
        if (st.backoff_left == 10'h000) begin
          next_st.tx_state = mac_flow_pkg::TX_SEND;
          next_st.tx_data_en = 1'b1;
          next_st.late = 1'b0;
          next_st.bit_cnt = 10'h000;
        end else if (bit_tick) begin
          next_st.bit_cnt = 10'(st.bit_cnt + 10'h001);
          if (st.bit_cnt == 10'(mac_flow_pkg::SLOT_BITS - 10'h001)) begin
            next_st.bit_cnt = 10'h000;
            next_st.backoff_left = 10'(st.backoff_left - 10'h001);
          end
        end
      end
      mac_flow_pkg::TX_PAUSE: begin
        if (pause_frame_sent) begin
          next_st.pause_frame_req = 1'b0;
          next_st.tx_state = mac_flow_pkg::TX_IDLE;
        end
      end
      default: begin
        next_st.tx_state = mac_flow_pkg::TX_IDLE;
        next_st.tx_data_en = 1'b0;
        next_st.tx_jam = 1'b0;
      end
    endcase
    if ((next_st.tx_state != mac_flow_pkg::TX_SEND) && st.pause_hold) begin
      next_st.pause_hold = 1'b0;
      next_st.pause_timer = st.pause_hold_val;
      next_st.pause_bits = 9'h000;
    end

    // Automatic pause generation with hysteresis
    // Placed after the idle state's take so a same-cycle request is not lost
    if (st.tx_pause_enable) begin
      if (flow_on && st.flow_armed) begin
        next_st.pause_req_pend = 1'b1;
        next_st.pause_req_val = st.pause_time_value;
        next_st.flow_armed = 1'b0;
      end else if (flow_off && !st.flow_armed) begin
        next_st.pause_req_pend = 1'b1;
        next_st.pause_req_val = 16'h0000;
        next_st.flow_armed = 1'b1;
      end
    end

    // Power state
    if (suspend_enter) begin
      next_st.suspended = 1'b1;
    end

    // AXI write: address and data taken in either order
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_got = 1'b1;
      next_st.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    if (st.aw_got && st.w_got && !st.bvalid) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = mapped(st.waddr) ? mac_flow_pkg::RESP_OKAY : mac_flow_pkg::RESP_SLVERR;
      w = merge(read_reg(st, st.waddr), st.wdata, st.wstrb);
      case (st.waddr)
        mac_flow_pkg::OFF_HARDWARE_CONFIG_REG: begin
          next_st.half_duplex = w[mac_flow_pkg::CFG_HALF] && (w[mac_flow_pkg::CFG_SPEED +: 2] != mac_flow_pkg::SPEED_GIG);
          next_st.speed = w[mac_flow_pkg::CFG_SPEED +: 2];
          next_st.retry_disable = w[mac_flow_pkg::CFG_NORETRY];
          next_st.fcs_en = w[mac_flow_pkg::CFG_FCS];
          next_st.pad_en = w[mac_flow_pkg::CFG_PAD];
          next_st.pad_strip = w[mac_flow_pkg::CFG_STRIP];
          next_st.backoff_limit_sel = w[mac_flow_pkg::CFG_BACKOFF_LIMIT_SEL +: 2];
        end
        mac_flow_pkg::OFF_FLOW: begin
          next_st.rx_pause_enable = w[mac_flow_pkg::FLOW_RXEN];
          next_st.tx_pause_enable = w[mac_flow_pkg::FLOW_TXEN];
          next_st.forward_pause_enable = w[mac_flow_pkg::FLOW_FWD];
          next_st.pause_time_value = w[mac_flow_pkg::FLOW_TIME +: 16];
          if (st.wstrb[0] && st.wdata[mac_flow_pkg::FLOW_FORCE]) begin
            next_st.pause_req_pend = 1'b1;
            next_st.pause_req_val = w[mac_flow_pkg::FLOW_TIME +: 16];
          end
        end
        mac_flow_pkg::OFF_WAKE_A: begin
          next_st.wake_en[3:0] = w[3:0];
          if (st.wstrb[0]) begin
            next_st.wake_sts[3:0] = st.wake_sts[3:0] & ~st.wdata[7:4];
          end
        end
        mac_flow_pkg::OFF_WAKE_B: begin
          next_st.wake_en[5:4] = w[1:0];
          if (st.wstrb[0]) begin
            next_st.wake_sts[5:4] = st.wake_sts[5:4] & ~st.wdata[5:4];
          end
        end
        mac_flow_pkg::OFF_PMT: begin
          next_st.lan_wake_enable = w[mac_flow_pkg::PMT_WOL];
          next_st.resume_clears_status = w[mac_flow_pkg::PMT_CLR_STS];
          next_st.resume_clears_enables = w[mac_flow_pkg::PMT_CLR_EN];
        end
        mac_flow_pkg::OFF_WAKE_CAUSE: begin
          if (st.wstrb[0]) begin
            next_st.wake_cause = st.wake_cause & ~st.wdata[5:0];
          end
        end
        default: begin
        end
      endcase
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    next_st.awready = !next_st.aw_got && !next_st.bvalid;
    next_st.wready = !next_st.w_got && !next_st.bvalid;

    // Resume clears, then hardware wake events set; a set wins over any clear
    if (resume_sig) begin
      if (st.resume_clears_status) begin
        next_st.wake_sts = 6'h00;
      end
      if (st.resume_clears_enables) begin
        next_st.wake_en = 6'h00;
      end
      next_st.suspended = 1'b0;
      next_st.wake_req = 1'b0;
    end
    hits = wake_match & st.wake_en;
    if (st.lan_wake_enable && (st.wake_en != 6'h00) && st.suspended && (hits != 6'h00)) begin
      next_st.wake_sts = next_st.wake_sts | hits;
      next_st.wake_cause = next_st.wake_cause | hits;
      next_st.wake_req = 1'b1;
      next_st.store_wake_frame = suspend_rx_store;
    end
    next_st.normal = !next_st.suspended;

    // AXI read
    if (s_axi_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = read_reg(st, s_axi_araddr);
      next_st.rresp = mapped(s_axi_araddr) ? mac_flow_pkg::RESP_OKAY : mac_flow_pkg::RESP_SLVERR;
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    next_st.arready = !next_st.rvalid;
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.tx_state <= mac_flow_pkg::TX_IDLE;
      st.lfsr <= mac_flow_pkg::LFSR_SEED;
      st.speed <= mac_flow_pkg::RST_SPEED;
      st.fcs_en <= 1'b1;
      st.pad_en <= 1'b1;
      st.flow_armed <= 1'b1;
      st.normal <= 1'b1;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs, all straight from the state register
  // ****************************************
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign tx_data_en = st.tx_data_en;
  assign tx_jam = st.tx_jam;
  assign frame_replay_req = st.frame_replay_req;
  assign frame_done_ind = st.frame_done_ind;
  assign pause_frame_req = st.pause_frame_req;
  assign pause_frame_time = st.pause_frame_time;
  assign tx_fcs_on = st.fcs_en;
  assign tx_pad_on = st.pad_en;
  assign rx_pad_strip = st.pad_strip;
  assign half_duplex_active = st.half_duplex;
  assign tx_paused = st.pause_req_pend;
  assign rx_forward_ctl = st.rx_forward_ctl;
  assign wake_req = st.wake_req;
  assign store_wake_frame = st.store_wake_frame;
  assign normal_state = st.normal;

endmodule

`default_nettype wire

// File: sim/phy_link_model.sv
`timescale 1ns/1ps
`default_nettype none

module phy_link_model (
  // Line status
  output logic link_clk,
  output logic phy_collision,
  // Bench control
  input wire logic collide
);
  // Receive clock runs free once the link is up; the odd offset keeps it off the bus clock edges
  initial begin
    link_clk = 1'b0;
    #7;
    forever #160 link_clk = ~link_clk;
  end
  assign phy_collision = collide;
endmodule

`default_nettype wire

// File: sim/mac_flow_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module mac_flow_checker (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Transmit side
  input wire logic tx_jam,
  input wire logic tx_data_en,
  input wire logic frame_replay_req,
  input wire logic frame_done_ind,
  input wire logic pause_frame_req,
  input wire logic pause_frame_sent,
  input wire logic [15:0] pause_frame_time,
  // Receive and wake side
  input wire logic rx_ctl_frame,
  input wire logic rx_forward_ctl,
  input wire logic store_wake_frame,
  input wire logic wake_req,
  // Register bus
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_jam_no_data: assert property (tx_jam |-> !tx_data_en) else $error("data during jam");
  a_jam_after_data: assert property ($rose(tx_jam) |-> $past(tx_data_en)) else $error("jam not from a frame");
  a_replay_pulse: assert property (ce && frame_replay_req |=> !frame_replay_req) else $error("replay too long");
  a_done_pulse: assert property (ce && frame_done_ind |=> !frame_done_ind) else $error("done too long");
  a_fwd_cause: assert property (ce && rx_forward_ctl |-> $past(rx_ctl_frame)) else $error("forward w/o frame");
  a_pause_hold: assert property (pause_frame_req && !pause_frame_sent |=> pause_frame_req && $stable(pause_frame_time))
    else $error("pause request dropped");
  a_store_wake: assert property (store_wake_frame |-> wake_req) else $error("store without wake");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
endmodule

bind mac_flow_wake mac_flow_checker chk_u (.*);

`default_nettype wire

// File: sim/gigabit_mac_flow_wake_control_bench.sv
`timescale 1ns/1ps
`default_nettype none

module gigabit_mac_flow_wake_control_bench;
  logic aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, link_clk, phy_collision, tx_frame_pending;
  logic tx_data_en, tx_jam, frame_replay_req, frame_done_ind, pause_frame_req, tx_fcs_on, tx_pad_on, rx_pad_strip;
  logic half_duplex_active, tx_paused, rx_da_reserved, rx_da_unicast, rx_forward_ctl, suspend_rx_store, wake_req;
  logic store_wake_frame, normal_state, collide;
  wire flow_on, flow_off, rx_ctl_frame, suspend_enter, resume_sig, pause_frame_sent, tx_frame_end;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [3:0] s_axi_wstrb;
  logic [5:0] wake_match;
  logic [6:0] pv;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [15:0] pause_frame_time, rx_ctl_opcode, rx_pause_quanta;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, t, hits;
  int bad_count, cmp_count, n;
  int pq[$];
  localparam logic [6:0] ON = 7'h01, OFF = 7'h02, CTL = 7'h04, SUSP = 7'h08, RES = 7'h10, SENT = 7'h20, TEND = 7'h40;
  assign {tx_frame_end, pause_frame_sent, resume_sig, suspend_enter, rx_ctl_frame, flow_off, flow_on} = pv;
  mac_flow_wake dut_u (.*);
  phy_link_model phy_u (.link_clk(link_clk), .phy_collision(phy_collision), .collide(collide));

  // ****************************************
  // Bus and check helpers
  // ****************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tmo(input int lim);
    if (n < lim) return;
    bad_count++;
    tally_and_finish();
  endtask
  task automatic wait_hi(ref logic s, input int lim);
    for (n = 0; n < lim && s !== 1'b1; n++) @(posedge aclk);
    tmo(lim);
  endtask
  task automatic pulse(input logic [6:0] m);
    @(posedge aclk);
    pv <= m;
    @(posedge aclk);
    pv <= 7'h0;
  endtask
  // One access at a time; each channel is released at the edge that takes it
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= {a, a, d, 4'hf};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    for (n = 0; n < 50 && s_axi_bvalid !== 1'b1 && s_axi_rvalid !== 1'b1; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    {s_axi_bready, s_axi_rready} <= 2'h0;
    {rsp, rd} = w ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata};
    tmo(50);
  endtask
  task automatic pause_chk;
    wait_hi(pause_frame_req, 400);
    chk(pause_frame_time, pq.pop_front());
    pulse(SENT);
  endtask

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, tx_frame_pending, pv} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, rx_ctl_opcode, rx_pause_quanta, wake_match} = '0;
    {rx_da_reserved, rx_da_unicast, suspend_rx_store, collide, bad_count, cmp_count} = '0;
    ce = 1'b1;
    void'($urandom(32'hd653));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    bus(1'b1, 8'h1c, $urandom);
    chk(rsp, mac_flow_pkg::RESP_SLVERR);
    t = $urandom_range(32'hffff, 1);
    pq = {t, t, 0, t};
    bus(1'b1, 8'h04, {t[15:0], 16'h8});
    chk(tx_paused, 1'b1);
    pause_chk();
    bus(1'b1, 8'h04, {t[15:0], 16'h2});
    pulse(ON);
    pause_chk();
    pulse(ON);
    repeat (100) @(posedge aclk);
    chk(pause_frame_req, 1'b0);
    pulse(OFF);
    pause_chk();
    pulse(ON);
    pause_chk();
    rx_ctl_opcode <= mac_flow_pkg::PAUSE_OPCODE;
    rx_da_reserved <= 1'b1;
    rx_pause_quanta <= 16'h1;
    bus(1'b1, 8'h04, 32'h4);
    ce <= 1'b0;
    pulse(CTL);
    @(posedge aclk);
    chk(rx_forward_ctl, 1'b0);
    ce <= 1'b1;
    pulse(CTL);
    @(posedge aclk);
    chk(rx_forward_ctl, 1'b1);
    bus(1'b1, 8'h04, 32'h1);
    bus(1'b1, 8'h00, 32'h35);
    chk(half_duplex_active, 1'b0);
    bus(1'b1, 8'h00, 32'h31);
    chk({tx_fcs_on, tx_pad_on, rx_pad_strip, half_duplex_active}, 4'hd);
    pulse(CTL);
    @(posedge aclk);
    chk(rx_forward_ctl, 1'b0);
    tx_frame_pending <= 1'b1;
    repeat (200) @(posedge aclk);
    chk(tx_data_en, 1'b0);
    wait_hi(tx_data_en, 6000);
    collide <= 1'b1;
    wait_hi(tx_jam, 50);
    collide <= 1'b0;
    wait_hi(frame_replay_req, 600);
    wait_hi(tx_data_en, 9000);
    tx_frame_pending <= 1'b0;
    pulse(TEND);
    wait_hi(frame_done_ind, 50);
    bus(1'b1, 8'h08, 32'hf);
    bus(1'b1, 8'h0c, 32'h3);
    bus(1'b1, 8'h10, 32'h7);
    suspend_rx_store <= 1'b1;
    pulse(SUSP);
    hits = $urandom_range(63, 0) | 32'h11;
    wake_match <= hits[5:0];
    @(posedge aclk);
    wake_match <= 6'h0;
    wait_hi(wake_req, 5);
    chk(store_wake_frame, 1'b1);
    chk(normal_state, 1'b0);
    bus(1'b0, 8'h08, 0);
    chk(rd, {hits[3:0], 4'hf});
    bus(1'b0, 8'h0c, 0);
    chk(rd, {hits[5:4], 4'h3});
    pulse(RES);
    bus(1'b0, 8'h08, 0);
    chk(rd, 0);
    bus(1'b0, 8'h14, 0);
    chk(rd, hits);
    bus(1'b0, 8'h10, 0);
    chk(rd[4], 1'b0);
    chk(normal_state, 1'b1);
    tally_and_finish();
  end
endmodule

`default_nettype wire
